// ==== include/tcr_pkg.sv ====
package tcr_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] TCR_OFF_MODE = 8'h00;
  localparam logic [7:0] TCR_OFF_OUTPUT = 8'h01;
  localparam logic [7:0] TCR_OFF_RSVD2 = 8'h02;
  localparam logic [7:0] TCR_OFF_STATUS = 8'h03;
  localparam logic [7:0] TCR_OFF_TOUCH_LO = 8'h04;
  localparam logic [7:0] TCR_OFF_TOUCH_HI = 8'h05;
  localparam logic [7:0] TCR_OFF_LATCH_LO = 8'h07;
  localparam logic [7:0] TCR_OFF_LATCH_HI = 8'h08;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int TCR_BIT_DEEP_SLEEP = 4;
  localparam int TCR_BIT_SOFT_RESET = 3;
  localparam int TCR_MODE_MSB = 2;
  localparam int TCR_OUT_MSB = 7;
  localparam int TCR_OUT_LSB = 4;
  localparam int TCR_BIT_FACTORY = 6;
  localparam int TCR_NUM_BUTTONS = 10;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] TCR_RST_MODE = 8'h00;
  localparam logic [7:0] TCR_RST_OUTPUT = 8'h00;
  localparam logic [7:0] TCR_RST_STATUS = 8'h00;
  localparam logic [7:0] TCR_RST_TOUCH = 8'h00;
  localparam logic [7:0] TCR_READ_ZERO = 8'h00;

  // Device modes
  typedef enum logic [2:0] {
    TCR_MODE_OPERATING = 3'h0,
    TCR_MODE_LED_CFG = 3'h1,
    TCR_MODE_DEV_CFG = 3'h2,
    TCR_MODE_PROD_TEST = 3'h3,
    TCR_MODE_DEBUG = 3'h4
  } tcr_mode_t;

  // Register access from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tcr_req_t;

  // Operation handshake toward the controller core
  typedef struct packed {
    logic sleep_req;
    logic soft_reset_req;
  } tcr_ops_t;

endpackage

// ==== hdl/tcr_sync.sv ====
`timescale 1ns/10ps
module tcr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // Destination clock
  input wire logic reset, // Synchronous reset
  input wire logic [WIDTH-1:0] async_in, // Signal from another domain
  output logic [WIDTH-1:0] sync_out // Synchronised copy
);

  logic [WIDTH-1:0] stage1_reg;

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1_reg <= '0;
      sync_out <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end

endmodule

// ==== hdl/tcr_regs.sv ====
`timescale 1ns/10ps
// How it works
// - Each register has a fixed access kind and power-on value, as coded in the map.
// - Reset loads every non-reserved register with its documented initial value.
// - Reserved registers always read as zero; the host must not rely on them.
// - Writing 1 to mode bit 4 starts deep sleep; bit clears when sleep ends.
// - Writing 1 to mode bit 3 resets the controller; writing 0 does nothing.
// - Self-clearing bits return to zero by themselves once their operation completes.
// - Mode bits 2:0 select operating, LED, device config, test or debug mode.
// - Output register bits 7:4 set host-controlled outputs 3:0 directly.
// - A stored 0 drives the output low, a stored 1 drives it high.
// - Status bit 6 reads 1 if factory defaults loaded, 0 for user config.
// - Touch-state low register bit x shows button x touched, for buttons 0 to 7.
// - Touch-state high register holds buttons 9 and 8 in bits 1:0, read-only.
// - Latched registers give latched touch status, buttons 0-7 then 8 and 9.
module tcr_regs
  import tcr_pkg::*;
#(
  parameter int NUM_BUTTONS = TCR_NUM_BUTTONS
) (
  input wire logic clk, // Device clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic link_clk, // Serial link clock
  input wire logic link_reset, // Link-domain reset, active high
  input wire tcr_pkg::tcr_req_t link_req, // Register access on link clock
  output logic [7:0] link_rdata, // Read data, link clock
  output logic link_busy, // Write still crossing
  input wire logic [NUM_BUTTONS-1:0] touch_in, // Live button sense pins
  input wire logic factory_loaded, // Defaults loaded strap
  input wire logic sleep_done, // Core reports deep sleep exit
  input wire logic reset_done, // Core reports soft reset done
  output tcr_pkg::tcr_ops_t ops, // Requests toward the core
  output tcr_pkg::tcr_mode_t device_mode, // Selected device mode
  output logic [3:0] host_output // Host-controlled output levels
);
  import tcr_pkg::*;

  // ----------------------------------------
  // Link-domain write capture
  // ----------------------------------------
  logic wr_toggle_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic ack_sync;
  logic ack_toggle_reg;

  // A write offered while busy is dropped; the host waits for it to fall
  assign link_busy = wr_toggle_reg != ack_sync;

  always_ff @(posedge link_clk) begin
    if (link_reset) begin
      wr_toggle_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else if (link_req.wr && !link_busy) begin
      wr_toggle_reg <= ~wr_toggle_reg;
      wr_addr_reg <= link_req.addr;
      wr_data_reg <= link_req.wdata;
    end
  end

  tcr_sync #(.WIDTH(1)) u_ack_sync (
    .clk(link_clk),
    .reset(link_reset),
    .async_in(ack_toggle_reg),
    .sync_out(ack_sync)
  );

  // ----------------------------------------
  // Device-domain write receive
  // ----------------------------------------
  logic req_sync;
  logic wr_fire;
  logic [7:0] dev_addr;
  logic [7:0] dev_data;

  tcr_sync #(.WIDTH(1)) u_req_sync (
    .clk(clk),
    .reset(reset),
    .async_in(wr_toggle_reg),
    .sync_out(req_sync)
  );

  // One-cycle strobe per write once its toggle has crossed
  assign wr_fire = req_sync != ack_toggle_reg;
  // Address and data are stable while the toggle is outstanding
  assign dev_addr = wr_addr_reg;
  assign dev_data = wr_data_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_toggle_reg <= 1'b0;
    end else begin
      ack_toggle_reg <= req_sync;
    end
  end

  // ----------------------------------------
  // Mode control register
  // ----------------------------------------
  logic deep_sleep_reg;
  logic soft_reset_reg;
  logic [2:0] mode_reg;
  logic mode_wr;

  assign mode_wr = wr_fire && (dev_addr == TCR_OFF_MODE);

  always_ff @(posedge clk) begin
    if (reset) begin
      deep_sleep_reg <= TCR_RST_MODE[TCR_BIT_DEEP_SLEEP];
    end else if (mode_wr && dev_data[TCR_BIT_DEEP_SLEEP]) begin
      deep_sleep_reg <= 1'b1;
    end else if (sleep_done) begin
      deep_sleep_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      soft_reset_reg <= TCR_RST_MODE[TCR_BIT_SOFT_RESET];
    end else if (mode_wr && dev_data[TCR_BIT_SOFT_RESET]) begin
      soft_reset_reg <= 1'b1;
    end else if (reset_done) begin
      soft_reset_reg <= 1'b0;
    end
  end

  // Invalid codes leave the mode as it was
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_reg <= TCR_RST_MODE[TCR_MODE_MSB:0];
    end else if (mode_wr && dev_data[TCR_MODE_MSB:0] <= 3'(TCR_MODE_DEBUG)) begin
      mode_reg <= dev_data[TCR_MODE_MSB:0];
    end
  end

  assign ops.sleep_req = deep_sleep_reg;
  assign ops.soft_reset_req = soft_reset_reg;
  assign device_mode = tcr_mode_t'(mode_reg);

  // ----------------------------------------
  // Host output register
  // ----------------------------------------
  logic [3:0] out_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      out_reg <= TCR_RST_OUTPUT[TCR_OUT_MSB:TCR_OUT_LSB];
    end else if (wr_fire && dev_addr == TCR_OFF_OUTPUT) begin
      out_reg <= dev_data[TCR_OUT_MSB:TCR_OUT_LSB];
    end
  end

  assign host_output = out_reg;

  // ----------------------------------------
  // Status and touch state
  // ----------------------------------------
  logic factory_sync;
  logic factory_reg;
  logic [NUM_BUTTONS-1:0] touch_sync;
  logic [NUM_BUTTONS-1:0] latch_reg;

  tcr_sync #(.WIDTH(1)) u_fac_sync (
    .clk(clk),
    .reset(reset),
    .async_in(factory_loaded),
    .sync_out(factory_sync)
  );

  tcr_sync #(.WIDTH(NUM_BUTTONS)) u_touch_sync (
    .clk(clk),
    .reset(reset),
    .async_in(touch_in),
    .sync_out(touch_sync)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      factory_reg <= TCR_RST_STATUS[TCR_BIT_FACTORY];
    end else begin
      factory_reg <= factory_sync;
    end
  end

  // Latched touch: any touch sets; a touch in the clearing cycle wins
  logic latch_clr_lo;
  logic latch_clr_hi;
  logic [NUM_BUTTONS-1:0] clr_mask;

  always_comb begin
    clr_mask = '0;
    if (latch_clr_lo) begin
      clr_mask[7:0] = 8'hFF;
    end
    if (latch_clr_hi) begin
      clr_mask[NUM_BUTTONS-1:8] = '1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      latch_reg <= '0;
    end else begin
      latch_reg <= (latch_reg & ~clr_mask) | touch_sync;
    end
  end

  // ----------------------------------------
  // Snapshot of readable state for the link domain
  // ----------------------------------------
  // These bits are independent levels, so two flops per bit suffice
  logic [7:0] status_word;
  logic [1:0] op_bits;
  logic [NUM_BUTTONS-1:0] touch_link;
  logic [NUM_BUTTONS-1:0] latch_link;
  logic [7:0] status_link;
  logic [1:0] op_link;
  logic [3:0] out_link;
  logic [2:0] mode_link_reg;
  logic ack_seen_reg;

  assign status_word = {1'b0, factory_reg, 6'h00};
  assign op_bits = {deep_sleep_reg, soft_reset_reg};

  tcr_sync #(.WIDTH(NUM_BUTTONS)) u_touch_link (
    .clk(link_clk),
    .reset(link_reset),
    .async_in(touch_sync),
    .sync_out(touch_link)
  );

  tcr_sync #(.WIDTH(NUM_BUTTONS)) u_latch_link (
    .clk(link_clk),
    .reset(link_reset),
    .async_in(latch_reg),
    .sync_out(latch_link)
  );

  tcr_sync #(.WIDTH(8)) u_stat_link (
    .clk(link_clk),
    .reset(link_reset),
    .async_in(status_word),
    .sync_out(status_link)
  );

  tcr_sync #(.WIDTH(2)) u_mode_link (
    .clk(link_clk),
    .reset(link_reset),
    .async_in(op_bits),
    .sync_out(op_link)
  );

  // ----------------------------------------
  // Mode code copy for the link domain
  // ----------------------------------------
  // The 3-bit code is taken whole once the write acknowledge has crossed,
  // so a read never sees half of a change; only host writes alter it
  always_ff @(posedge link_clk) begin
    if (link_reset) begin
      ack_seen_reg <= 1'b0;
      mode_link_reg <= TCR_RST_MODE[TCR_MODE_MSB:0];
    end else begin
      ack_seen_reg <= ack_sync;
      if (ack_sync != ack_seen_reg) begin
        mode_link_reg <= mode_reg;
      end
    end
  end

  tcr_sync #(.WIDTH(4)) u_out_link (
    .clk(link_clk),
    .reset(link_reset),
    .async_in(out_reg),
    .sync_out(out_link)
  );

  // ----------------------------------------
  // Link-domain read mux
  // ----------------------------------------
  function automatic logic [7:0] tcr_read(input logic [7:0] addr);
    logic [7:0] val;
    val = TCR_READ_ZERO;
    unique case (addr)
      TCR_OFF_MODE: val = {3'h0, op_link, mode_link_reg};
      TCR_OFF_OUTPUT: val = {out_link, 4'h0};
      TCR_OFF_STATUS: val = status_link;
      TCR_OFF_TOUCH_LO: val = touch_link[7:0];
      TCR_OFF_TOUCH_HI: val = {6'h00, touch_link[NUM_BUTTONS-1:8]};
      TCR_OFF_LATCH_LO: val = latch_link[7:0];
      TCR_OFF_LATCH_HI: val = {6'h00, latch_link[NUM_BUTTONS-1:8]};
      default: val = TCR_READ_ZERO;
    endcase
    return val;
  endfunction

  always_ff @(posedge link_clk) begin
    if (link_reset) begin
      link_rdata <= TCR_READ_ZERO;
    end else if (link_req.rd) begin
      link_rdata <= tcr_read(link_req.addr);
    end
  end

  // ----------------------------------------
  // Read-to-clear of latched status
  // ----------------------------------------
  // One toggle per register, so reads of both in quick succession stay apart
  logic [1:0] clr_toggle_reg;
  logic [1:0] clr_sync;
  logic [1:0] clr_seen_reg;

  always_ff @(posedge link_clk) begin
    if (link_reset) begin
      clr_toggle_reg <= 2'b00;
    end else if (link_req.rd && link_req.addr == TCR_OFF_LATCH_LO) begin
      clr_toggle_reg[0] <= ~clr_toggle_reg[0];
    end else if (link_req.rd && link_req.addr == TCR_OFF_LATCH_HI) begin
      clr_toggle_reg[1] <= ~clr_toggle_reg[1];
    end
  end

  tcr_sync #(.WIDTH(2)) u_clr_sync (
    .clk(clk),
    .reset(reset),
    .async_in(clr_toggle_reg),
    .sync_out(clr_sync)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      clr_seen_reg <= 2'b00;
    end else begin
      clr_seen_reg <= clr_sync;
    end
  end

  assign latch_clr_lo = clr_sync[0] != clr_seen_reg[0];
  assign latch_clr_hi = clr_sync[1] != clr_seen_reg[1];

endmodule

// ==== tb/tcr_regs_asserts.sv ====
`timescale 1ns/10ps
module tcr_regs_asserts
  import tcr_pkg::*;
#(
  parameter int NUM_BUTTONS = TCR_NUM_BUTTONS
) (
  input wire logic clk, // Device clock
  input wire logic reset, // Device reset
  input wire logic link_clk, // Link clock
  input wire logic link_reset, // Link reset
  input wire tcr_pkg::tcr_req_t link_req, // Register access
  input wire logic [7:0] link_rdata, // Read data
  input wire logic link_busy, // Write crossing
  input wire logic [NUM_BUTTONS-1:0] touch_in, // Button levels
  input wire logic factory_loaded, // Defaults strap
  input wire logic sleep_done, // Sleep exit
  input wire logic reset_done, // Soft reset done
  input wire tcr_pkg::tcr_ops_t ops, // Core requests
  input wire tcr_pkg::tcr_mode_t device_mode, // Mode select
  input wire logic [3:0] host_output // Output levels
);
  sequence s_rd(logic [7:0] a);
    link_req.rd && link_req.addr == a;
  endsequence
  property p_rst;
    @(posedge clk) disable iff (reset)
      $fell(reset) |-> ops == 2'b00 && device_mode == TCR_MODE_OPERATING && host_output == 4'h0;
  endproperty
  property p_sleep_hold;
    @(posedge clk) disable iff (reset) ops.sleep_req && !sleep_done |=> ops.sleep_req;
  endproperty
  property p_sleep_clr;
    @(posedge clk) disable iff (reset) sleep_done && ops.sleep_req |=> !ops.sleep_req;
  endproperty
  property p_srst_clr;
    @(posedge clk) disable iff (reset) reset_done && ops.soft_reset_req |=> !ops.soft_reset_req;
  endproperty
  property p_mode;
    @(posedge clk) disable iff (reset) device_mode <= 3'h4;
  endproperty
  property p_rsv;
    @(posedge link_clk) disable iff (link_reset) s_rd(TCR_OFF_RSVD2) |=> link_rdata == TCR_READ_ZERO;
  endproperty
  property p_hi;
    @(posedge link_clk) disable iff (link_reset) s_rd(TCR_OFF_TOUCH_HI) |=> link_rdata[7:2] == 6'h00;
  endproperty
  property p_stat;
    @(posedge link_clk) disable iff (link_reset)
      s_rd(TCR_OFF_STATUS) |=> {link_rdata[7], link_rdata[5:0]} == 7'h00;
  endproperty
  property p_out;
    @(posedge link_clk) disable iff (link_reset) s_rd(TCR_OFF_OUTPUT) |=> link_rdata[3:0] == 4'h0;
  endproperty
  property p_busy;
    @(posedge link_clk) disable iff (link_reset) link_req.wr && !link_busy |=> link_busy;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep request dropped early");
  a_sleep_clr: assert property (p_sleep_clr) else $error("sleep bit not cleared");
  a_srst_clr: assert property (p_srst_clr) else $error("soft reset bit not cleared");
  a_mode: assert property (p_mode) else $error("invalid mode taken");
  a_rsv: assert property (p_rsv) else $error("reserved register not zero");
  a_hi: assert property (p_hi) else $error("high touch reserved bits set");
  a_stat: assert property (p_stat) else $error("status reserved bits set");
  a_out: assert property (p_out) else $error("output reserved bits set");
  a_busy: assert property (p_busy) else $error("accepted write did not raise busy");
endmodule

bind tcr_regs tcr_regs_asserts #(.NUM_BUTTONS(NUM_BUTTONS)) u_asserts (.clk, .reset, .link_clk, .link_reset,
  .link_req, .link_rdata, .link_busy, .touch_in, .factory_loaded, .sleep_done, .reset_done, .ops, .device_mode,
  .host_output);

// ==== tb/tcr_host_model.sv ====
`timescale 1ns/10ps
module tcr_host_model
  import tcr_pkg::*;
(
  input wire logic link_clk, // Link clock
  input wire logic link_busy, // Write still crossing
  input wire logic [7:0] link_rdata, // Read data
  output tcr_pkg::tcr_req_t link_req // Register access
);
  initial link_req = '0;
  // Mode codes pass through as given; only the bench asks for invalid ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input int gap);
    repeat (gap) @(posedge link_clk);
    @(posedge link_clk);
    #1;
    link_req = '{1'b1, 1'b0, a, d};
    @(posedge link_clk);
    #1;
    link_req = '{1'b0, 1'b0, ~a, ~d};
    // A stuck busy is left for the bench watchdog to catch
    while (link_busy !== 1'b0) begin
      @(posedge link_clk);
      #1;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, input int gap);
    repeat (gap) @(posedge link_clk);
    @(posedge link_clk);
    #1;
    link_req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge link_clk);
    #1;
    link_req = '{1'b0, 1'b0, ~a, 8'hff};
    d = link_rdata;
  endtask
endmodule

// ==== tb/tb_tcr_regs.sv ====
`timescale 1ns/10ps
module tb_tcr_regs;
  import tcr_pkg::*;
  logic clk = 0, reset = 1, link_clk = 0, link_reset = 1;
  logic [9:0] touch_in = '0;
  logic [9:0] lat = '0;
  logic factory_loaded = 0, sleep_done = 0, reset_done = 0;
  tcr_req_t link_req;
  logic [7:0] link_rdata;
  logic link_busy;
  tcr_ops_t ops;
  tcr_mode_t device_mode;
  logic [3:0] host_output;
  logic [2:0] mode_exp;
  logic [31:0] lfsr = 32'h804b_3684;
  logic [7:0] ro_addr [5] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h20};
  int fails = 0, cmp_count = 0;

  always #4 clk = ~clk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  tcr_regs dut (.clk(clk), .reset(reset), .link_clk(link_clk), .link_reset(link_reset), .link_req(link_req),
    .link_rdata(link_rdata), .link_busy(link_busy), .touch_in(touch_in), .factory_loaded(factory_loaded),
    .sleep_done(sleep_done), .reset_done(reset_done), .ops(ops), .device_mode(device_mode),
    .host_output(host_output));
  tcr_host_model host (.link_clk(link_clk), .link_busy(link_busy), .link_rdata(link_rdata), .link_req(link_req));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [2:0] exp_mode(input logic [2:0] prev, input logic [2:0] code);
    return (code <= 3'h4) ? code : prev;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.rd(a, v, 2);
    chk(v, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic slp);
    wt(1);
    sleep_done = slp;
    reset_done = !slp;
    wt(1);
    sleep_done = 0;
    reset_done = 0;
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    wt(3);
    reset = 0;
    link_reset = 0;
    wt(4);
    for (int a = 0; a < 9; a++) rdchk(a[7:0], 8'h00);
    chk({3'h0, ops, device_mode}, 8'h00);
    chk({4'h0, host_output}, 8'h00);
    mode_exp = 3'h0;
    for (int m = 0; m < 8; m++) begin
      host.wr(TCR_OFF_MODE, {5'h00, m[2:0]}, m % 3);
      mode_exp = exp_mode(mode_exp, m[2:0]);
      chk({5'h00, device_mode}, {5'h00, mode_exp});
      rdchk(TCR_OFF_MODE, {5'h00, mode_exp});
    end
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      host.wr(TCR_OFF_OUTPUT, (i == 0) ? 8'hf0 : lfsr[7:0], i % 2);
      chk({4'h0, host_output}, (i == 0) ? 8'h0f : {4'h0, lfsr[7:4]});
      rdchk(TCR_OFF_OUTPUT, (i == 0) ? 8'hf0 : {lfsr[7:4], 4'h0});
    end
    for (int b = 3; b <= 4; b++) begin
      host.wr(TCR_OFF_MODE, (8'h01 << b) | 8'h04, 0);
      chk({6'h00, ops}, {6'h00, b == 4, b == 3});
      rdchk(TCR_OFF_MODE, (8'h01 << b) | 8'h04);
      pulse(b == 4);
      chk({6'h00, ops}, 8'h00);
      rdchk(TCR_OFF_MODE, 8'h04);
    end
    host.wr(TCR_OFF_MODE, 8'h04, 1);
    chk({6'h00, ops}, 8'h00);
    for (int f = 1; f >= 0; f--) begin
      wt(1);
      factory_loaded = f[0];
      wt(10);
      rdchk(TCR_OFF_STATUS, {1'b0, f[0], 6'h00});
    end
    for (int i = 0; i < 6; i++) begin
      lfsr = nxt(lfsr);
      wt(1);
      touch_in = (i == 0) ? 10'h3ff : lfsr[9:0];
      lat = lat | touch_in;
      wt(10);
      rdchk(TCR_OFF_TOUCH_LO, touch_in[7:0]);
      rdchk(TCR_OFF_TOUCH_HI, {6'h00, touch_in[9:8]});
    end
    wt(1);
    touch_in = '0;
    wt(10);
    rdchk(TCR_OFF_LATCH_LO, lat[7:0]);
    rdchk(TCR_OFF_LATCH_HI, {6'h00, lat[9:8]});
    rdchk(TCR_OFF_LATCH_LO, 8'h00);
    foreach (ro_addr[i]) host.wr(ro_addr[i], 8'hff, i);
    foreach (ro_addr[i]) rdchk(ro_addr[i], 8'h00);
    test_done;
  end

  initial begin
    #200000;
    fails++;
    test_done;
  end
endmodule
